// >>> core/tiop_pkg.sv
// Constants and types for the timed I/O port
// Assumes one 100 MHz system clock that is also the tile reference
package tiop_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int DATA_W     = 32;
  localparam int PIN_W      = 32;
  localparam int CNT_W      = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int NUM_CB     = 6;
  localparam int DIV_W      = 8;
  localparam int BEAT_W     = 6;
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  localparam int SYS_FREQ_MHZ = 100;
  localparam int REF_FREQ_MHZ = 100;
  localparam int REF_TICK_CYC = SYS_FREQ_MHZ / REF_FREQ_MHZ;
  localparam logic [DIV_W-1:0] REF_DIV_LIM = DIV_W'(REF_TICK_CYC - 1);
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [2:0]       CB_RST  = 3'h0;
  localparam logic             PD_RST  = 1'b1;
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    TIOP_W1  = 3'h0,
    TIOP_W4  = 3'h1,
    TIOP_W8  = 3'h2,
    TIOP_W16 = 3'h3,
    TIOP_W32 = 3'h4
  } tiop_width_t;
  typedef enum logic [1:0] {
    TIOP_COND_NONE = 2'h0,
    TIOP_COND_EQ   = 2'h1,
    TIOP_COND_NEQ  = 2'h2
  } tiop_cond_t;
  typedef enum logic [1:0] {
    TIOP_ST_IDLE  = 2'h0,
    TIOP_ST_SHIFT = 2'h1,
    TIOP_ST_PUSH  = 2'h3
  } tiop_state_t;
endpackage : tiop_pkg

// >>> core/tiop_port.sv
// Timed I/O port: FIFO, serializer, port counter, six clock blocks
// Assumes control inputs come from logic on sys_clk; pins are asynchronous
`timescale 1ns/1ns

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module tiop_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,       // Clock
  input  wire logic         rst_n,     // Sync reset
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Space left
  input  wire logic [W-1:0] in_data,   // Write word
  output logic              out_valid, // Word held
  input  wire logic         out_ready, // Read request
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   count;
  } tiop_fifo_regs_t;
  tiop_fifo_regs_t r, next_r;
  logic [W-1:0] mem [DEPTH];
  logic push, pop;
  assign in_ready  = r.count != (AW+1)'(DEPTH);
  assign out_valid = r.count != '0;
  assign out_data  = mem[r.rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_comb begin
    next_r = r;
    if (push) next_r.wptr = r.wptr + 1'b1;
    if (pop) next_r.rptr = r.rptr + 1'b1;
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) r <= '0;
    else r <= next_r;
    if (push) mem[r.wptr] <= in_data;
  end
endmodule : tiop_fifo

// Behaviour
// - Widths 1,4,8,16,32; one direction per port
// - Drive or sample pins, optionally conditioned
// - Core access answered within one cycle
// - Open drain: zero pulls low, one floats
// - Data passes serdes and transfer FIFO
// - Sixteen-bit counter times transfers
// - Counter readable; transfers deferred to value
// - Counter captured as timestamp per transfer
// - Enabled link disconnects shared port pins
// - Narrower enabled port overrules wider port
// - Port always transfers nominal width
// - Six clock blocks; block zero reference
// - Clock block sourced from one-bit port
// - Optional division of port-sourced clock
// - Strobe in qualifies input; strobe out
// - Reset attaches port to block zero
// - Pin conditions raise events, not interrupts
// - Pull-downs enabled during reset
module tiop_port
  import tiop_pkg::*;
(
  input  wire logic                          sys_clk,       // 100 MHz clock
  input  wire logic                          rst_n,         // Sync reset
  input  wire tiop_pkg::tiop_width_t         port_width,    // Port width
  input  wire logic                          port_is_out,   // 1 output, 0 input
  input  wire logic                          od_en,         // Open drain
  input  wire logic                          link_en,       // Link owns pins
  input  wire logic [tiop_pkg::PIN_W-1:0]    pin_claim,     // Pins held by narrower ports
  input  wire logic [2:0]                    clk_sel,       // Clock block choice
  input  wire logic                          clk_sel_wr,    // Load clk_sel
  input  wire logic [tiop_pkg::NUM_CB-1:0]   cb_src_ext,    // Block fed by ext pin
  input  wire logic [tiop_pkg::NUM_CB-1:0][tiop_pkg::DIV_W-1:0] cb_div, // Divide minus one
  input  wire logic                          timed_en,      // Defer to timed_value
  input  wire logic [tiop_pkg::CNT_W-1:0]    timed_value,   // Transfer time
  input  wire tiop_pkg::tiop_cond_t          cond_mode,     // Pin wait mode
  input  wire logic [tiop_pkg::PIN_W-1:0]    cond_value,    // Pin wait value
  input  wire logic                          strobe_in_en,  // Qualify with strobe
  input  wire logic                          strobe_out_en, // Emit strobe
  input  wire logic                          ext_clk_pin,   // One-bit port clock
  input  wire logic                          strobe_in_pin, // Incoming ready
  input  wire logic [tiop_pkg::PIN_W-1:0]    pin_in,        // Pin levels
  output logic [tiop_pkg::PIN_W-1:0]         pin_out,       // Pin drive value
  output logic [tiop_pkg::PIN_W-1:0]         pin_oe,        // Pin drive enable
  output logic                               pull_down_en,  // Pin pull-downs
  output logic                               strobe_out,    // Outgoing ready
  input  wire logic                          core_wr,       // Core output word
  input  wire logic [tiop_pkg::DATA_W-1:0]   core_wdata,    // Core word
  output logic                               core_wr_ack,   // Word taken
  output logic                               core_wr_nack,  // Word refused
  input  wire logic                          core_rd,       // Core input request
  output logic                               core_rd_ack,   // Word returned
  output logic                               core_rd_empty, // Nothing to return
  output logic [tiop_pkg::DATA_W-1:0]        core_rdata,    // Returned word
  output logic [tiop_pkg::CNT_W-1:0]         port_count,    // Port counter
  output logic [tiop_pkg::CNT_W-1:0]         port_stamp,    // Last timestamp
  output logic                               pin_event      // Condition met
);
  import tiop_pkg::*;

  typedef struct packed {
    logic [2:0][PIN_W-1:0]         pin_sync;
    logic [PIN_W-1:0]              pin_val;
    logic [2:0]                    eclk_sync;
    logic                          eclk_val;
    logic [2:0]                    stb_sync;
    logic                          stb_val;
    logic [NUM_CB-1:0][DIV_W-1:0]  div_cnt;
    logic [2:0]                    cb_cur;
    logic [CNT_W-1:0]              count;
    logic [CNT_W-1:0]              stamp;
    tiop_state_t                   state;
    logic [DATA_W-1:0]             shreg;
    logic [BEAT_W-1:0]             beats;
    logic [PIN_W-1:0]              pin_out;
    logic [PIN_W-1:0]              pin_oe;
    logic                          pull_down_en;
    logic                          strobe_out;
    logic                          pin_event;
    logic                          wr_ack;
    logic                          wr_nack;
    logic                          rd_ack;
    logic                          rd_empty;
    logic [DATA_W-1:0]             rdata;
  } tiop_regs_t;

  tiop_regs_t r, next_r;

  logic              f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [DATA_W-1:0] f_in_data, f_out_data;
  logic [BEAT_W-1:0] wbits, nbeats;
  logic [PIN_W-1:0]  wmask, sample;
  logic [NUM_CB-1:0] fired;
  logic              eclk_rise, tick, time_ok, cond_ok, xfer;

  assign pin_out       = r.pin_out;
  assign pin_oe        = r.pin_oe;
  assign pull_down_en  = r.pull_down_en;
  assign strobe_out    = r.strobe_out;
  assign core_wr_ack   = r.wr_ack;
  assign core_wr_nack  = r.wr_nack;
  assign core_rd_ack   = r.rd_ack;
  assign core_rd_empty = r.rd_empty;
  assign core_rdata    = r.rdata;
  assign port_count    = r.count;
  assign port_stamp    = r.stamp;
  assign pin_event     = r.pin_event;

  // ----------------------------------------
  // Transfer FIFO, filled by core or deserializer
  // ----------------------------------------
  assign f_in_valid  = port_is_out ? core_wr : (r.state == TIOP_ST_PUSH);
  assign f_in_data   = port_is_out ? core_wdata : r.shreg;
  assign f_out_ready = port_is_out ? (r.state == TIOP_ST_IDLE) : core_rd;

  tiop_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  always_comb begin
    next_r = r;
    // ----------------------------------------
    // Pin synchronisers, change taken once stages 2 and 3 agree
    // ----------------------------------------
    next_r.pin_sync  = {r.pin_sync[1:0], pin_in};
    next_r.eclk_sync = {r.eclk_sync[1:0], ext_clk_pin};
    next_r.stb_sync  = {r.stb_sync[1:0], strobe_in_pin};
    for (int b = 0; b < PIN_W; b++) begin
      if (r.pin_sync[1][b] == r.pin_sync[2][b]) next_r.pin_val[b] = r.pin_sync[2][b];
    end
    if (r.eclk_sync[1] == r.eclk_sync[2]) next_r.eclk_val = r.eclk_sync[2];
    if (r.stb_sync[1] == r.stb_sync[2]) next_r.stb_val = r.stb_sync[2];
    eclk_rise = next_r.eclk_val & ~r.eclk_val;
    // ----------------------------------------
    // Clock blocks: block 0 reference, others divided
    // ----------------------------------------
    for (int i = 0; i < NUM_CB; i++) begin
      logic             src;
      logic [DIV_W-1:0] lim;
      src = 1'b1;
      lim = REF_DIV_LIM;
      if (i != 0) begin
        src = cb_src_ext[i] ? eclk_rise : 1'b1;
        lim = cb_div[i];
      end
      fired[i] = src && (r.div_cnt[i] == lim);
      if (src) next_r.div_cnt[i] = fired[i] ? '0 : r.div_cnt[i] + 1'b1;
    end
    if (clk_sel_wr && (clk_sel < 3'(NUM_CB))) next_r.cb_cur = clk_sel;
    tick = fired[r.cb_cur];
    next_r.count = r.count + CNT_W'(tick);
    // ----------------------------------------
    // Width, condition and timing gates
    // ----------------------------------------
    case (port_width)
      TIOP_W1:  wbits = 6'h01;
      TIOP_W4:  wbits = 6'h04;
      TIOP_W8:  wbits = 6'h08;
      TIOP_W16: wbits = 6'h10;
      default:  wbits = 6'h20;
    endcase
    nbeats  = BEAT_W'(DATA_W / int'(wbits));
    wmask   = (wbits == 6'h20) ? '1 : ((PIN_W'(1) << wbits) - PIN_W'(1));
    sample  = r.pin_val & wmask;
    time_ok = !timed_en || (r.count == timed_value);
    case (cond_mode)
      TIOP_COND_EQ:  cond_ok = sample == (cond_value & wmask);
      TIOP_COND_NEQ: cond_ok = sample != (cond_value & wmask);
      default:       cond_ok = 1'b1;
    endcase
    xfer = 1'b0;
    next_r.strobe_out = 1'b0;
    next_r.pin_event  = 1'b0;
    next_r.pull_down_en = 1'b0;
    // ----------------------------------------
    // Serializer and deserializer
    // ----------------------------------------
    case (r.state)
      TIOP_ST_IDLE: begin
        if (port_is_out) begin
          if (f_out_valid) begin
            next_r.shreg = f_out_data;
            next_r.beats = '0;
            next_r.state = TIOP_ST_SHIFT;
          end
        end else if (tick && time_ok && cond_ok && (!strobe_in_en || r.stb_val)) begin
          xfer = 1'b1;
          next_r.pin_event = cond_mode != TIOP_COND_NONE;
          next_r.beats = 6'h01;
          next_r.shreg = (r.shreg >> wbits) | (DATA_W'(sample) << (DATA_W - int'(wbits)));
          next_r.state = (nbeats == 6'h01) ? TIOP_ST_PUSH : TIOP_ST_SHIFT;
        end
      end
      TIOP_ST_SHIFT: begin
        if (port_is_out) begin
          if (tick && ((r.beats != '0) || time_ok)) begin
            xfer = 1'b1;
            next_r.pin_out = r.shreg[PIN_W-1:0] & wmask;
            next_r.shreg = r.shreg >> wbits;
            next_r.strobe_out = strobe_out_en;
            next_r.beats = r.beats + 1'b1;
            if (r.beats == nbeats - 1'b1) next_r.state = TIOP_ST_IDLE;
          end
        end else if (tick && (!strobe_in_en || r.stb_val)) begin
          xfer = 1'b1;
          next_r.shreg = (r.shreg >> wbits) | (DATA_W'(sample) << (DATA_W - int'(wbits)));
          next_r.beats = r.beats + 1'b1;
          if (r.beats == nbeats - 1'b1) next_r.state = TIOP_ST_PUSH;
        end
      end
      TIOP_ST_PUSH: begin
        if (port_is_out || f_in_ready) next_r.state = TIOP_ST_IDLE;
      end
      default: next_r.state = TIOP_ST_IDLE;
    endcase
    if (xfer) next_r.stamp = r.count;
    // ----------------------------------------
    // Pin drive: link, narrower ports, open drain
    // ----------------------------------------
    next_r.pin_oe = (port_is_out && !link_en) ? (wmask & ~pin_claim) : '0;
    if (od_en) next_r.pin_oe = next_r.pin_oe & ~next_r.pin_out;
    // ----------------------------------------
    // Core accesses answered next cycle
    // ----------------------------------------
    next_r.wr_ack   = core_wr && port_is_out && f_in_ready;
    next_r.wr_nack  = core_wr && !(port_is_out && f_in_ready);
    next_r.rd_ack   = core_rd && !port_is_out && f_out_valid;
    next_r.rd_empty = core_rd && !(!port_is_out && f_out_valid);
    if (next_r.rd_ack) next_r.rdata = f_out_data;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r              <= '0;
      r.cb_cur       <= CB_RST;
      r.count        <= CNT_RST;
      r.pull_down_en <= PD_RST;
      r.state        <= TIOP_ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_count_step: assert property (tick |=> port_count == $past(port_count) + 16'h0001)
    else $error("port counter missed a tick");
  a_count_hold: assert property (!tick |=> $stable(port_count))
    else $error("port counter moved without tick");
  a_stamp_take: assert property (xfer |=> port_stamp == $past(port_count))
    else $error("timestamp not captured");
  a_timed_start: assert property (port_is_out && xfer && r.beats == '0 && timed_en |-> port_count == timed_value)
    else $error("timed output started early");
  a_od_float: assert property ($past(od_en) && $past(rst_n) |-> (pin_oe & pin_out) == '0)
    else $error("open drain drove a one");
  a_link_off: assert property ($past(link_en) && $past(rst_n) |-> pin_oe == '0)
    else $error("pins driven under link");
  a_claim_yield: assert property ($past(rst_n) |-> (pin_oe & $past(pin_claim)) == '0)
    else $error("claimed pin driven");
  a_read_answer: assert property (core_rd |=> core_rd_ack != core_rd_empty)
    else $error("core read unanswered");
  a_write_answer: assert property (core_wr |=> core_wr_ack != core_wr_nack)
    else $error("core write unanswered");
  a_event_cause: assert property (pin_event |-> $past(cond_mode) != TIOP_COND_NONE && $past(cond_ok))
    else $error("event without condition");
  a_reset_block: assert property ($past(!rst_n) |-> r.cb_cur == CB_RST && pull_down_en)
    else $error("reset state wrong");
  a_pd_release: assert property ($past(rst_n) |-> !pull_down_en)
    else $error("pull-downs left on after reset");
  a_oe_width: assert property ((pin_oe & ~$past(wmask)) == '0)
    else $error("pin driven outside port width");
  a_wr_refuse: assert property (core_wr && !port_is_out |=> core_wr_nack)
    else $error("input port took a core word");

  c_out_word: cover property (port_is_out && xfer && r.beats == nbeats - 1'b1);
  c_in_push: cover property (r.state == TIOP_ST_PUSH && f_in_ready);
  c_cond_event: cover property (pin_event);
  c_ext_clock: cover property (tick && cb_src_ext[r.cb_cur]);
  c_timed_out: cover property (port_is_out && xfer && timed_en);
endmodule : tiop_port

// >>> dv/tb_timed_io_port_with_clock_blocks.sv
// Self-checking bench for the timed I/O port
// Assumes tiop_port and tiop_far_end are compiled before it
`timescale 1ns/1ns
module tb_timed_io_port_with_clock_blocks;
  import tiop_pkg::*;
  logic                           sys_clk = 1'b0, rst_n = 1'b0;
  tiop_width_t                    port_width = TIOP_W32;
  tiop_cond_t                     cond_mode = TIOP_COND_NONE;
  logic                           port_is_out = 1'b0, od_en = 1'b0, link_en = 1'b0, clk_sel_wr = 1'b0;
  logic                           timed_en = 1'b0, strobe_in_en = 1'b1, strobe_out_en = 1'b1;
  logic                           core_wr = 1'b0, core_rd = 1'b0, got;
  logic [31:0]                    pin_claim = '0, cond_value = '0, core_wdata = '0, msk = '1, pat;
  logic [31:0]                    rnd = 32'h000156E7;
  logic [2:0]                     clk_sel = 3'h0;
  logic [NUM_CB-1:0]              cb_src_ext = '0;
  logic [NUM_CB-1:0][DIV_W-1:0]   cb_div = '0;
  logic [15:0]                    timed_value = '0, c0;
  wire logic                      ext_clk_pin, strobe_in_pin, pull_down_en, strobe_out, pin_event;
  wire logic                      core_wr_ack, core_wr_nack, core_rd_ack, core_rd_empty;
  wire logic [31:0]               pin_in, pin_out, pin_oe, core_rdata;
  wire logic [15:0]               port_count, port_stamp;
  int                             fails = 0, total_checks = 0, cycles = 0, ev_cnt = 0, n;
  logic [31:0]                    exp_beats[$];

  always #5 sys_clk = ~sys_clk;

  tiop_port DUT (.sys_clk, .rst_n, .port_width, .port_is_out, .od_en, .link_en, .pin_claim, .clk_sel,
    .clk_sel_wr, .cb_src_ext, .cb_div, .timed_en, .timed_value, .cond_mode, .cond_value, .strobe_in_en,
    .strobe_out_en, .ext_clk_pin, .strobe_in_pin, .pin_in, .pin_out, .pin_oe, .pull_down_en, .strobe_out,
    .core_wr, .core_wdata, .core_wr_ack, .core_wr_nack, .core_rd, .core_rd_ack, .core_rd_empty, .core_rdata,
    .port_count, .port_stamp, .pin_event);
  tiop_far_end far (.pin_out, .pin_oe, .pull_down_en, .pin_in, .strobe_in_pin, .ext_clk_pin);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk_word(input logic [31:0] got_v, input logic [31:0] exp_v);
    total_checks++;
    if (got_v !== exp_v) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got_v, input logic exp_v);
    chk_word({31'h0, got_v}, {31'h0, exp_v});
  endtask : chk_bit
  task automatic tick(input int k = 1);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic set_width(input tiop_width_t wd);
    int b;
    b = (wd == TIOP_W1) ? 1 : 4 << (int'(wd) - 1);
    port_width = wd;
    msk = (b == 32) ? 32'hFFFFFFFF : (32'h1 << b) - 32'h1;
  endtask : set_width
  task automatic core_write(input logic [31:0] d);
    int b;
    b = $countones(msk);
    core_wr = 1'b1;
    core_wdata = d;
    tick();
    chk_bit(core_wr_ack, port_is_out);
    chk_bit(core_wr_nack, ~port_is_out);
    for (int k = 0; port_is_out && k < 32 / b; k++)
      exp_beats.push_back((d >> (k * b)) & msk);
  endtask : core_write
  task automatic core_read(input logic [31:0] e, output logic ok);
    core_rd = 1'b1;
    tick();
    ok = core_rd_ack;
    if (ok === 1'b1)
      chk_word(core_rdata, e);
    else
      chk_bit(core_rd_empty, 1'b1);
  endtask : core_read
  task automatic rest();
    core_wr = 1'b0;
    core_rd = 1'b0;
    tick();
  endtask : rest

  // ----------------------------------------
  // Model comparison and watchdog
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst_n && strobe_out === 1'b1 && port_is_out && exp_beats.size() > 0)
      chk_word(pin_out & msk, exp_beats.pop_front());
    else if (rst_n && strobe_out !== 1'b0)
      chk_bit(strobe_out, 1'b0);
    if (pin_event === 1'b1)
      ev_cnt++;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    tick(3);
    chk_bit(pull_down_en, 1'b1);
    chk_word(pin_oe, 32'h0);
    tick(3);
    rst_n = 1'b1;
    tick(3);
    chk_bit(pull_down_en, 1'b0);
    c0 = port_count;
    tick(10);
    chk_word(32'(16'(port_count - c0)), 32'hA);
    $display("test reset done");
    port_is_out = 1'b1;
    for (int i = 0; i < 5; i++) begin
      set_width(tiop_width_t'(i));
      tick(2);
      repeat (2) begin
        rnd = lfsr(rnd);
        core_write(rnd);
      end
      rest();
      tick(90);
      chk_word(exp_beats.size(), 32'h0);
      chk_word(pin_oe, msk);
    end
    pin_claim = 32'h0000FF00;
    tick(2);
    chk_word(pin_oe, 32'hFFFF00FF);
    link_en = 1'b1;
    tick(2);
    chk_word(pin_oe, 32'h0);
    link_en = 1'b0;
    pin_claim = '0;
    $display("test output done");
    timed_en = 1'b1;
    timed_value = port_count + 16'h0032;
    core_write(rnd);
    rest();
    for (n = 0; strobe_out !== 1'b1 && n < 200; n++)
      tick();
    tick();
    chk_bit(n > 40, 1'b1);
    chk_word(port_stamp, timed_value);
    timed_en = 1'b0;
    set_width(TIOP_W4);
    od_en = 1'b1;
    core_write(32'hA0000000);
    rest();
    tick(20);
    chk_word(pin_oe, 32'h5);
    chk_word(pin_in & 32'h5, 32'h0);
    od_en = 1'b0;
    core_read(32'h0, got);
    rest();
    $display("test timed done");
    set_width(TIOP_W32);
    port_is_out = 1'b0;
    pat = lfsr(rnd);
    far.drive(pat);
    tick(8);
    core_write(pat);
    core_wr = 1'b0;
    core_read(pat, got);
    rest();
    chk_bit(got, 1'b0);
    far.set_strobe(1'b1);
    tick(80);
    far.set_strobe(1'b0);
    tick(10);
    n = 0;
    do begin
      core_read(pat, got);
      n += int'(got === 1'b1);
    end while (got === 1'b1 && n < 40);
    rest();
    chk_bit(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2, 1'b1);
    $display("test fill done");
    set_width(TIOP_W8);
    for (int m = 1; m < 3; m++) begin
      far.drive(pat);
      cond_mode = tiop_cond_t'(m);
      cond_value = (m == 1) ? pat ^ 32'h1 : pat;
      strobe_in_en = 1'b0;
      tick(10);
      ev_cnt = 0;
      tick(20);
      chk_word(ev_cnt, 32'h0);
      far.drive(pat ^ 32'h1);
      tick(15);
      chk_bit(ev_cnt > 0, 1'b1);
    end
    strobe_in_en = 1'b1;
    cond_mode = TIOP_COND_NONE;
    $display("test condition done");
    cb_src_ext = 6'h02;
    for (int d = 0; d < 3; d++) begin
      cb_div[1] = DIV_W'(d);
      clk_sel = 3'h1;
      clk_sel_wr = 1'b1;
      tick();
      clk_sel_wr = 1'b0;
      tick(5);
      c0 = port_count;
      far.ext_burst(12);
      tick(10);
      chk_word(32'(16'(port_count - c0)), 32'(12 / (d + 1)));
    end
    $display("test clock block done");
    test_done();
  end
endmodule : tb_timed_io_port_with_clock_blocks

// >>> dv/tiop_far_end.sv
// Far-side hardware model for the timed I/O port pins
// Assumes the bench steers pin drive, strobe and clock bursts by task calls
`timescale 1ns/1ns
module tiop_far_end
  import tiop_pkg::*;
(
  input  wire logic [tiop_pkg::PIN_W-1:0] pin_out,       // Device drive value
  input  wire logic [tiop_pkg::PIN_W-1:0] pin_oe,        // Device drive enable
  input  wire logic                       pull_down_en,  // Device pull-downs
  output logic [tiop_pkg::PIN_W-1:0]      pin_in,        // Resolved pin levels
  output logic                            strobe_in_pin, // Ready to device
  output logic                            ext_clk_pin    // Application clock
);
  logic [PIN_W-1:0] drv_val = '0;
  logic             drv_on  = 1'b0;
  logic             churn   = 1'b0;
  initial begin
    strobe_in_pin = 1'b0;
    ext_clk_pin   = 1'b0;
  end
  // Floating pins wander so stale values never pass
  always #3 churn = ~churn;
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (drv_on)
        pin_in[i] = drv_val[i];
      else
        pin_in[i] = pull_down_en ? 1'b0 : churn ^ i[0];
    end
  end
  task automatic drive(input logic [PIN_W-1:0] v);
    drv_val = v;
    drv_on  = 1'b1;
  endtask : drive
  task automatic set_strobe(input logic s);
    strobe_in_pin = s;
  endtask : set_strobe
  // Clock stands still between bursts
  task automatic ext_burst(input int n);
    repeat (n) begin
      #40 ext_clk_pin = 1'b1;
      #40 ext_clk_pin = 1'b0;
    end
  endtask : ext_burst
endmodule : tiop_far_end
